// ==== verilog/pad_pkg.sv ====
// Package for the PCI address/data and command/byte-enable lane block
package pad_pkg;
	// ---------------------------------------------------------------
	// Bus widths and field positions
	// ---------------------------------------------------------------
	localparam int AD_W = 32; // Address/data lane count
	localparam int CBE_W = 4; // Command/byte-enable line count
	localparam logic [1:0] BURST_LINEAR = 2'h0; // Low address bits for linear burst
	localparam logic [3:0] CMD_MEM_READ = 4'h6; // Memory read command code
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7; // Memory write command code
	localparam logic [3:0] CMD_CFG_READ = 4'ha; // Configuration read command code
	localparam logic [3:0] CMD_CFG_WRITE = 4'hb; // Configuration write command code
	localparam logic [31:0] BAR_RESET = 32'h0000_0000; // Target window base reset value
	localparam logic [31:0] BAR_MASK_RESET = 32'hffff_ff00; // Target window mask

	// Lane phases
	typedef enum logic [2:0] {PAD_IDLE, PAD_M_ADDR, PAD_M_DATA, PAD_T_DATA, PAD_RELEASE} pad_state_t;

	// Master request from the DMA side
	typedef struct packed {
		logic valid; // Request present
		logic write; // Write when set
		logic [29:0] dword_addr; // Doubleword address
		logic [31:0] wdata; // FIFO write data, little-endian
		logic [3:0] byte_en_n; // Byte enables, low active, physical lanes
	} pad_mreq_t;

	// Captured data toward the user side
	typedef struct packed {
		logic valid; // One-cycle strobe
		logic from_target; // Set when captured as a target write
		logic [31:0] data; // Data in local order
		logic [3:0] byte_en_n; // Enables on physical lanes
	} pad_rdata_t;

	// Byte reversal used for big-endian FIFO data
	function automatic logic [31:0] pad_swap(input logic [31:0] d, input logic en);
		pad_swap = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction

	// Even parity over lanes and command/enable lines
	function automatic logic pad_parity(input logic [31:0] ad, input logic [3:0] cbe);
		pad_parity = ^{ad, cbe};
	endfunction
endpackage

// ==== verilog/pad_lanes.sv ====
// Lane steering for PCI address/data and command/byte-enable lines
// Notes on behaviour
// - Address first clock, data on later clocks
// - Little-endian lanes unless swapping is on; target data never swapped
// - Swap bit reorders FIFO data big-endian
// - Master address drives low two bits zero
// - Monitor lanes for address match when idle
// - Drive lanes on master write, target read
// - Capture lanes on master read, target write
// - Reset held: all lanes are inputs only
// - Initiator drives command in address phase
// - Enables qualify physical lanes in data
// - Enables follow lanes regardless of swap
// - Released low-active line driven high once
// - Parity is even over lanes and commands
`timescale 1ns/1ps
module pad_lanes
	import pad_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Control
	input wire logic BYTE_SWAP_ENABLE,
	input wire logic GRANT,
	input wire pad_mreq_t MREQ,
	input wire logic [31:0] TGT_RDATA,
	// Pins, address/data
	input wire logic [31:0] AD_IN,
	output logic [31:0] AD_OUT,
	output logic AD_OE,
	// Pins, command/byte enables
	input wire logic [3:0] CBE_N_IN,
	output logic [3:0] CBE_N_OUT,
	output logic CBE_OE,
	// Pins, framing and parity
	input wire logic FRAME_N_IN,
	output logic FRAME_N_OUT,
	output logic FRAME_OE,
	input wire logic IRDY_N_IN,
	input wire logic TRDY_N_IN,
	output logic PAR_OUT,
	output logic PAR_OE,
	// User side
	output logic MREQ_TAKEN,
	output pad_rdata_t RDATA,
	output logic TGT_HIT
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [31:0] ad_s1, ad_s; // Lane samples, two stages
	logic [3:0] cbe_s1, cbe_s; // Command/enable samples
	logic frame_s1, frame_s, frame_d; // Frame samples and delayed copy
	logic irdy_s1, irdy_s, trdy_s1, trdy_s; // Handshake samples
	logic grant_s1, grant_s; // Bus grant samples

	// Two flops before any logic reads a pin
	always_ff @(posedge MCLK) begin
		ad_s1 <= AD_IN;
		ad_s <= ad_s1;
		cbe_s1 <= CBE_N_IN;
		cbe_s <= cbe_s1;
		frame_s1 <= FRAME_N_IN;
		frame_s <= frame_s1;
		frame_d <= frame_s;
		irdy_s1 <= IRDY_N_IN;
		irdy_s <= irdy_s1;
		trdy_s1 <= TRDY_N_IN;
		trdy_s <= trdy_s1;
		grant_s1 <= GRANT;
		grant_s <= grant_s1;
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	pad_state_t state, next_state; // Lane phase
	logic [31:0] ad_out, next_ad_out; // Lane output
	logic ad_oe, next_ad_oe; // Lane drive enable
	logic [3:0] cbe_out, next_cbe_out; // Command/enable output
	logic cbe_oe, next_cbe_oe; // Command/enable drive
	logic frame_out, next_frame_out; // Frame, low active
	logic frame_oe, next_frame_oe; // Frame drive
	logic par_out, next_par_out; // Parity output
	logic par_oe, next_par_oe; // Parity drive, one clock behind lanes
	logic taken, next_taken; // Request accepted pulse
	pad_rdata_t rdata, next_rdata; // Captured data
	logic tgt_hit, next_tgt_hit; // Address match pulse
	logic m_write, next_m_write; // Master direction held
	logic t_read, next_t_read; // Target read in progress
	logic [31:0] bar; // Target window base
	logic addr_phase; // Frame just fell: address on the lanes
	logic hit; // Address matches window

	assign bar = BAR_RESET;
	// Address is present on the first clock of the frame
	assign addr_phase = !frame_s && frame_d;
	// Match watched only while not master
	assign hit = addr_phase && ((ad_s & BAR_MASK_RESET) == bar);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_ad_out = ad_out;
		next_ad_oe = ad_oe;
		next_cbe_out = cbe_out;
		next_cbe_oe = cbe_oe;
		next_frame_out = frame_out;
		next_frame_oe = frame_oe;
		// As a target the enables on the bus belong to the initiator
		next_par_out = pad_parity(ad_out, cbe_oe ? cbe_out : cbe_s);
		next_par_oe = ad_oe;
		next_taken = 1'b0;
		next_rdata = '0;
		next_tgt_hit = 1'b0;
		next_m_write = m_write;
		next_t_read = t_read;
		case (state)
			PAD_IDLE: begin
				// Idle: lanes are inputs and watched for a match
				next_ad_oe = 1'b0;
				next_cbe_oe = 1'b0;
				next_frame_oe = 1'b0;
				if (MREQ.valid && grant_s && frame_s) begin
					// Address phase: dword address, low bits zero
					next_ad_out = {MREQ.dword_addr, BURST_LINEAR};
					next_cbe_out = MREQ.write ? CMD_MEM_WRITE : CMD_MEM_READ;
					next_ad_oe = 1'b1;
					next_cbe_oe = 1'b1;
					next_frame_out = 1'b0;
					next_frame_oe = 1'b1;
					next_m_write = MREQ.write;
					next_taken = 1'b1;
					next_state = PAD_M_ADDR;
				end else if (hit) begin
					// Claimed as target; reads turn the lanes around
					next_tgt_hit = 1'b1;
					next_t_read = !cbe_s[0];
					next_state = PAD_T_DATA;
				end
			end
			PAD_M_ADDR: begin
				// Single data phase; frame goes high as it starts
				next_frame_out = 1'b1;
				next_cbe_out = MREQ.byte_en_n;
				if (m_write) begin
					// Master write drives FIFO data, swapped when the swap bit is set
					next_ad_out = pad_swap(MREQ.wdata, BYTE_SWAP_ENABLE);
				end else begin
					next_ad_oe = 1'b0;
				end
				next_state = PAD_M_DATA;
			end
			PAD_M_DATA: begin
				if (!trdy_s) begin
					if (!m_write) begin
						// Master read captures and restores local order
						next_rdata.valid = 1'b1;
						next_rdata.data = pad_swap(ad_s, BYTE_SWAP_ENABLE);
						next_rdata.byte_en_n = cbe_out;
					end
					next_ad_oe = 1'b0;
					next_cbe_oe = 1'b0;
					next_state = PAD_RELEASE;
				end
			end
			PAD_T_DATA: begin
				if (t_read) begin
					// Target read: little-endian, never swapped
					next_ad_out = TGT_RDATA;
					next_ad_oe = 1'b1;
				end
				// A read ends only after one clock with its data on the lanes
				if (!irdy_s && (!t_read || ad_oe)) begin
					if (!t_read) begin
						next_rdata.valid = 1'b1;
						next_rdata.from_target = 1'b1;
						next_rdata.data = ad_s;
						next_rdata.byte_en_n = cbe_s;
					end
					next_ad_oe = 1'b0;
					next_state = PAD_IDLE;
				end
			end
			PAD_RELEASE: begin
				// Frame already high; now let it float
				next_frame_oe = 1'b0;
				next_state = PAD_IDLE;
			end
			default: next_state = PAD_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			// All lanes released so the test chain sees inputs
			state <= PAD_IDLE;
			ad_out <= '0;
			ad_oe <= 1'b0;
			cbe_out <= '1;
			cbe_oe <= 1'b0;
			frame_out <= 1'b1;
			frame_oe <= 1'b0;
			par_out <= 1'b0;
			par_oe <= 1'b0;
			taken <= 1'b0;
			rdata <= '0;
			tgt_hit <= 1'b0;
			m_write <= 1'b0;
			t_read <= 1'b0;
		end else begin
			state <= next_state;
			ad_out <= next_ad_out;
			ad_oe <= next_ad_oe;
			cbe_out <= next_cbe_out;
			cbe_oe <= next_cbe_oe;
			frame_out <= next_frame_out;
			frame_oe <= next_frame_oe;
			par_out <= next_par_out;
			par_oe <= next_par_oe;
			taken <= next_taken;
			rdata <= next_rdata;
			tgt_hit <= next_tgt_hit;
			m_write <= next_m_write;
			t_read <= next_t_read;
		end
	end

	assign AD_OUT = ad_out;
	assign AD_OE = ad_oe;
	assign CBE_N_OUT = cbe_out;
	assign CBE_OE = cbe_oe;
	assign FRAME_N_OUT = frame_out;
	assign FRAME_OE = frame_oe;
	assign PAR_OUT = par_out;
	assign PAR_OE = par_oe;
	assign MREQ_TAKEN = taken;
	assign RDATA = rdata;
	assign TGT_HIT = tgt_hit;
endmodule

// ==== sim/pad_lanes_properties.sv ====
// Checker for the lane block
`timescale 1ns/1ps
module pad_lanes_properties
	import pad_pkg::*;
(
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic BYTE_SWAP_ENABLE,
	input wire pad_mreq_t MREQ,
	input wire logic [31:0] AD_OUT,
	input wire logic AD_OE,
	input wire logic [3:0] CBE_N_OUT,
	input wire logic CBE_OE,
	input wire logic [3:0] CBE_N_IN,
	input wire logic FRAME_N_OUT,
	input wire logic FRAME_OE,
	input wire logic PAR_OUT,
	input wire logic PAR_OE,
	input wire logic MREQ_TAKEN
);
	logic [31:0] wd; // Write data in lane order
	logic [31:0] w;
	logic [3:0] cbe_bus; // Enables as they stand on the bus
	assign w = MREQ.wdata;
	assign cbe_bus = CBE_OE ? CBE_N_OUT : CBE_N_IN;
	assign wd = BYTE_SWAP_ENABLE ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	a_addr_phase: assert property (@(posedge MCLK) disable iff (SYS_RST)
		MREQ_TAKEN |-> AD_OE && AD_OUT == {MREQ.dword_addr, 2'h0}) else $error("bad address");
	a_cmd_code: assert property (@(posedge MCLK) disable iff (SYS_RST)
		MREQ_TAKEN |-> CBE_OE && CBE_N_OUT == (MREQ.write ? CMD_MEM_WRITE : CMD_MEM_READ))
		else $error("bad command");
	a_wdata_lanes: assert property (@(posedge MCLK) disable iff (SYS_RST)
		MREQ_TAKEN && MREQ.write |=> AD_OE && AD_OUT == $past(wd)) else $error("bad data");
	a_byte_enables: assert property (@(posedge MCLK) disable iff (SYS_RST)
		MREQ_TAKEN && MREQ.write |=> CBE_N_OUT == $past(MREQ.byte_en_n)) else $error("bad enables");
	a_read_float: assert property (@(posedge MCLK) disable iff (SYS_RST)
		MREQ_TAKEN && !MREQ.write |=> !AD_OE) else $error("lanes driven on read");
	a_par_even: assert property (@(posedge MCLK) disable iff (SYS_RST)
		PAR_OE |-> PAR_OUT == ^{$past(AD_OUT), $past(cbe_bus)}) else $error("bad parity");
	a_frame_park: assert property (@(posedge MCLK) disable iff (SYS_RST)
		$fell(FRAME_OE) |-> $past(FRAME_N_OUT)) else $error("frame not parked high");
	a_reset_float: assert property (@(posedge MCLK)
		SYS_RST |=> !AD_OE && !CBE_OE && !FRAME_OE && !PAR_OE) else $error("driven in reset");
endmodule
bind pad_lanes pad_lanes_properties u_props (.MCLK, .SYS_RST, .BYTE_SWAP_ENABLE, .MREQ,
	.AD_OUT, .AD_OE, .CBE_N_OUT, .CBE_OE, .CBE_N_IN, .FRAME_N_OUT, .FRAME_OE, .PAR_OUT, .PAR_OE,
	.MREQ_TAKEN);

// ==== sim/pad_target_model.sv ====
// Far-side target that answers the block's master transfers
`timescale 1ns/1ps
module pad_target_model
	import pad_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe_n,
	input wire logic frame_n,
	input wire logic frame_oe,
	input wire logic [3:0] wait_n,
	input wire logic [31:0] rd_word,
	output logic trdy_n,
	output logic ad_oe,
	output logic [31:0] addr,
	output logic [3:0] cmd,
	output logic [31:0] wr_word,
	output logic [3:0] wr_be,
	output logic done
);
	logic busy;
	logic [3:0] cnt;
	// Wait states come from the bench so both prompt and slow answers occur
	always @(posedge clk) begin
		done <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
			trdy_n <= 1'b1;
			ad_oe <= 1'b0;
		end else if (!busy && frame_oe && !frame_n) begin
			addr <= ad;
			cmd <= cbe_n;
			cnt <= wait_n;
			busy <= 1'b1;
		end else if (busy && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else if (busy && trdy_n) begin
			trdy_n <= 1'b0;
			ad_oe <= (cmd == CMD_MEM_READ);
			wr_word <= ad;
			wr_be <= cbe_n;
		end else if (busy && !frame_oe) begin
			trdy_n <= 1'b1;
			ad_oe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b1;
		end
	end
endmodule

// ==== sim/tb_pci_addr_data_byte_lanes.sv ====
// Testbench for the lane block
`timescale 1ns/1ps
module tb_pci_addr_data_byte_lanes;
	import pad_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic swap = 1'b0;
	logic grant = 1'b0;
	pad_mreq_t mreq = '0;
	pad_rdata_t rdata;
	logic [31:0] tgt_rdata = 32'h0, ti_ad = 32'h0, ag_word = 32'h0;
	logic [3:0] ti_cbe = 4'hf, ag_wait = 4'h0;
	logic ti_frame = 1'b1, ti_irdy = 1'b1;
	logic [31:0] ad_out, ag_addr, ag_wr;
	logic [3:0] cbe_out, ag_cmd, ag_be;
	logic ad_oe, cbe_oe, frame_out, frame_oe, par_out, par_oe, taken, hit;
	logic ag_trdy, ag_oe, ag_done;
	int mismatches = 0, n_compared = 0;
	// Resolved pins, every party's enable taken into account
	wire [31:0] ad_in = ad_oe ? ad_out : (ag_oe ? ag_word : ti_ad);
	wire [3:0] cbe_in = cbe_oe ? cbe_out : ti_cbe;
	wire frame_in = frame_oe ? frame_out : ti_frame;
	always #25 mclk = ~mclk;
	pad_lanes DUT (.MCLK(mclk), .SYS_RST(sys_rst), .BYTE_SWAP_ENABLE(swap), .GRANT(grant),
		.MREQ(mreq), .TGT_RDATA(tgt_rdata), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe),
		.CBE_N_IN(cbe_in), .CBE_N_OUT(cbe_out), .CBE_OE(cbe_oe), .FRAME_N_IN(frame_in),
		.FRAME_N_OUT(frame_out), .FRAME_OE(frame_oe), .IRDY_N_IN(ti_irdy), .TRDY_N_IN(ag_trdy),
		.PAR_OUT(par_out), .PAR_OE(par_oe), .MREQ_TAKEN(taken), .RDATA(rdata), .TGT_HIT(hit));
	pad_target_model AGENT (.clk(mclk), .rst(sys_rst), .ad(ad_in), .cbe_n(cbe_in),
		.frame_n(frame_in), .frame_oe(frame_oe), .wait_n(ag_wait), .rd_word(ag_word),
		.trdy_n(ag_trdy), .ad_oe(ag_oe), .addr(ag_addr), .cmd(ag_cmd), .wr_word(ag_wr),
		.wr_be(ag_be), .done(ag_done));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] rev(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction
	// Reset with the pins wiggling: nothing may be driven
	task automatic reset_chk();
		@(posedge mclk);
		sys_rst <= 1'b1;
		ti_frame <= 1'b0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		ti_frame <= 1'b1;
		@(negedge mclk);
		chk("oe", 32'h0, {ad_oe, cbe_oe, frame_oe, par_oe});
		repeat (3) @(posedge mclk);
	endtask
	// One master transfer against the far-side target
	task automatic master(input logic wr, sw, input logic [29:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int i;
		@(posedge mclk);
		swap <= sw;
		grant <= 1'b1;
		ag_word <= d;
		ag_wait <= {2'h0, a[1:0]};
		mreq <= '{1'b1, wr, a, d, be};
		for (i = 0; i < 20 && taken !== 1'b1; i++) @(negedge mclk);
		chk("taken", 32'h1, taken);
		@(posedge mclk);
		mreq.valid <= !wr;
		for (i = 0; i < 40 && !wr && rdata.valid !== 1'b1; i++) @(negedge mclk);
		if (!wr) chk("rdata", sw ? rev(d) : d, rdata.data);
		@(posedge mclk);
		mreq.valid <= 1'b0;
		for (i = 0; i < 40 && ag_done !== 1'b1; i++) @(negedge mclk);
		chk("addr", {a, 2'h0}, ag_addr);
		chk("cmd", wr ? CMD_MEM_WRITE : CMD_MEM_READ, ag_cmd);
		if (wr) chk("wdata", sw ? rev(d) : d, ag_wr);
		if (wr) chk("be", be, ag_be);
	endtask
	// The bench as initiator, swap left on to show targets never swap
	task automatic target(input logic [3:0] cmd, input logic [31:0] a, d, input logic h);
		int i;
		@(posedge mclk);
		swap <= 1'b1;
		tgt_rdata <= d;
		ti_ad <= a;
		ti_cbe <= cmd;
		ti_frame <= 1'b0;
		@(posedge mclk);
		ti_frame <= 1'b1;
		ti_ad <= cmd[0] ? d : ~d;
		ti_cbe <= 4'h5;
		ti_irdy <= 1'b0;
		for (i = 0; i < 8 && hit !== 1'b1; i++) @(negedge mclk);
		chk("hit", h, hit);
		for (i = 0; i < 20 && h && !cmd[0] && ad_oe !== 1'b1; i++) @(negedge mclk);
		if (h && !cmd[0]) chk("tgt_oe", 32'h1, ad_oe);
		if (h && !cmd[0]) chk("tgt_rd", d, ad_out);
		for (i = 0; i < 20 && h && cmd[0] && rdata.valid !== 1'b1; i++) @(negedge mclk);
		if (h && cmd[0]) chk("tgt_wr", {d[31:0]}, rdata.data);
		if (h && cmd[0]) chk("tgt_be", {rdata.from_target, 4'h5}, {rdata.from_target, rdata.byte_en_n});
		for (i = 0; i < 20 && ad_oe !== 1'b0; i++) @(negedge mclk);
		@(posedge mclk);
		ti_irdy <= 1'b1;
		ti_ad <= ~ti_ad;
		repeat (3) @(posedge mclk);
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge mclk);
		mismatches++;
		close_out();
	end
	initial begin
		reset_chk();
		master(1, 0, 30'h0400_0010, 32'h1122_3344, 4'h0);
		master(1, 1, 30'h0400_0011, 32'h1122_3344, 4'h6);
		master(0, 1, 30'h0400_0012, 32'ha1b2_c3d4, 4'h0);
		master(0, 0, 30'h0400_0013, 32'ha1b2_c3d4, 4'h9);
		target(CMD_CFG_WRITE, 32'h0000_0040, 32'h5566_7788, 1);
		target(CMD_CFG_READ, 32'h0000_0044, 32'h99aa_bbcc, 1);
		target(CMD_CFG_WRITE, 32'h0001_0040, 32'h0000_0001, 0);
		reset_chk();
		master(1, 0, 30'h0400_0020, 32'hdead_0001, 4'hc);
		close_out();
	end
endmodule
